// ==== rss_regs.sv ====
// Function
// - bit 7 enables temperature-driven auto calibration; here it only drives auto_rx_calibration_enable, moved never starts a run
// - write 1 bit 6 starts calibration, standby
// - bit 5 reads 1 while calibration runs
// - temperature moved flag beyond threshold since calibration
// - threshold codes 5/10/15/20 degrees, reset 10
// - monitor off stops; none in sleep/standby
// - temperature readout read-only, minus one per degree
// - supply detector enable bit 3, trim reset 010
// - mode ready sets on reach, clears change
// - rx/tx settled flags, clear leaving mode
// - lock flag follows synthesizer lock in fs/rx/tx
// - rssi flag sets in rx, w1c, leave clears
// - timeout flag read-only, clears leave rx/empty
// - preamble flag sets on detect, w1c
// - sync flag; w1c only in continuous mode
// - full flag exactly at 66 bytes
// - empty flag when buffer holds no bytes
// - level flag when count exceeds limit
// - overrun flag, w1c empties buffer, not sleep
// - packet sent sets in tx, clears leaving
// - payload ready and crc ok clear on empty
// - low supply flag sticky until write 1
//
// Added by the designer: the Wishbone interface to the registers.
module rss_regs
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [7:0]  wb_dat_i,
    input  wire logic        wb_sel_i,
    output logic [7:0]       wb_dat_o,
    output logic             wb_ack_o,
    // radio core status
    input  wire logic [2:0]  mode,
    input  wire logic        continuous_mode,
    input  wire logic        mode_reached,
    input  wire logic        rx_settle_done,
    input  wire logic        tx_ramp_done,
    input  wire logic        pll_lock,
    input  wire logic        rssi_above,
    input  wire logic        rx_timeout,
    input  wire logic        preamble_hit,
    input  wire logic        sync_hit,
    input  wire logic [6:0]  fifo_count,
    input  wire logic        fifo_overrun,
    input  wire logic        packet_done,
    input  wire logic        payload_done,
    input  wire logic        crc_good,
    input  wire logic        supply_below,
    input  wire logic [7:0]  temp_sensor,
    // controls to the radio core
    output logic             auto_rx_calibration_enable,
    output logic             rx_calibration_active,
    output logic             supply_detector_enable,
    output logic [2:0]       supply_threshold_select,
    output logic             fifo_flush
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [1:0] temperature_delta_limit_q;    // threshold code
    logic       thermal_monitor_disable_q;    // monitor off
    logic [5:0] buffer_level_limit_q;         // fifo threshold
    logic [7:0] flags1_q;                     // event flags, first
    logic       overflow_q;                   // buffer overflow sticky
    logic       sent_q;                       // frame sent
    logic       payload_q;                    // frame received
    logic       crc_q;                        // check passed
    logic       supply_low_flag_q;                     // supply low sticky
    logic [2:0] mode_q;                       // previous mode

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic       req;          // new access this cycle
    logic       wr;           // write strobe
    logic       cal_start;    // calibration start pulse
    logic       cal_busy;     // from sequencer
    logic       cal_done;     // calibration finished pulse
    logic       mon_en;       // monitoring active
    logic       moved;        // temperature moved
    logic [7:0] reading;      // sampled temperature
    logic       mode_chg;     // mode changed this cycle
    logic       in_rx;        // receive mode
    logic       in_tx;        // transmit mode
    logic       fifo_empty;   // empty level
    logic       w1c_rssi;
    logic       w1c_pre;
    logic       w1c_sync;
    logic       w1c_ovr;
    logic       w1c_bat;

    // address match used by the write decode and control register writes; readback uses its own case
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    always_comb
    begin
        req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wr         = req && wb_we_i && wb_sel_i;
        in_rx      = (mode == rss_pkg::RSS_RX);
        in_tx      = (mode == rss_pkg::RSS_TX);
        mode_chg   = (mode != mode_q);
        fifo_empty = (fifo_count == 7'h00);
        // start only honoured in standby
        cal_start  = wr && hit(wb_adr_i, rss_pkg::ADDR_IMAGE_CAL)
                     && wb_dat_i[rss_pkg::CAL_TRIG_BIT]
                     && (mode == rss_pkg::RSS_STANDBY);
        // monitoring off in sleep, standby or when disabled
        mon_en     = !thermal_monitor_disable_q
                     && (mode != rss_pkg::RSS_SLEEP)
                     && (mode != rss_pkg::RSS_STANDBY);
        w1c_rssi   = wr && hit(wb_adr_i, rss_pkg::ADDR_FLAGS1)
                     && wb_dat_i[rss_pkg::F1_RSSI_BIT];
        w1c_pre    = wr && hit(wb_adr_i, rss_pkg::ADDR_FLAGS1)
                     && wb_dat_i[rss_pkg::F1_PRE_BIT];
        w1c_sync   = wr && hit(wb_adr_i, rss_pkg::ADDR_FLAGS1)
                     && wb_dat_i[rss_pkg::F1_SYNC_BIT]
                     && continuous_mode;
        w1c_ovr    = wr && hit(wb_adr_i, rss_pkg::ADDR_FLAGS2)
                     && wb_dat_i[rss_pkg::F2_OVR_BIT];
        w1c_bat    = wr && hit(wb_adr_i, rss_pkg::ADDR_FLAGS2)
                     && wb_dat_i[rss_pkg::F2_SUPPLY_LOW_FLAG_BIT];
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    rss_cal_seq u_cal
    (
        .clk    (clk),
        .rstn   (rstn),
        .ce     (ce),
        .start  (cal_start),
        .active (cal_busy),
        .done   (cal_done)
    );

    rss_temp_mon u_temp
    (
        .clk         (clk),
        .rstn        (rstn),
        .ce          (ce),
        .enable      (mon_en),
        .sensor      (temp_sensor),
        .cal_done    (cal_done),
        .delta_limit (temperature_delta_limit_q),
        .reading     (reading),
        .moved       (moved)
    );

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            auto_rx_calibration_enable <= 1'b0;
            temperature_delta_limit_q  <= rss_pkg::RST_DELTA_LIMIT;
            thermal_monitor_disable_q  <= 1'b0;
            supply_detector_enable     <= 1'b0;
            supply_threshold_select    <= rss_pkg::RST_SUPPLY_TRIM;
            buffer_level_limit_q       <= rss_pkg::RST_FIFO_LIMIT;
        end
        else if (ce && wr)
        begin
            if (hit(wb_adr_i, rss_pkg::ADDR_IMAGE_CAL))
            begin
                auto_rx_calibration_enable <= wb_dat_i[rss_pkg::CAL_AUTO_BIT];
                temperature_delta_limit_q  <= wb_dat_i[rss_pkg::CAL_LIMIT_LSB +: 2];
                thermal_monitor_disable_q  <= wb_dat_i[rss_pkg::CAL_MONOFF_BIT];
            end
            if (hit(wb_adr_i, rss_pkg::ADDR_SUPPLY))
            begin
                supply_detector_enable  <= wb_dat_i[rss_pkg::SUP_EN_BIT];
                supply_threshold_select <= wb_dat_i[2:0];
            end
            if (hit(wb_adr_i, rss_pkg::ADDR_FIFO_LIMIT))
                buffer_level_limit_q <= wb_dat_i[5:0];
        end
    end

    // calibration running mirror, registered output
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rx_calibration_active <= 1'b0;
        else if (ce)
            rx_calibration_active <= cal_busy || cal_start;
    end

    // ------------------------------------------------------------------
    // first flag register; set wins over any clear except on the rx/tx flags, where leaving the mode wins
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flags1_q <= 8'h00;
            mode_q   <= rss_pkg::RSS_SLEEP;
        end
        else if (ce)
        begin
            mode_q <= mode;
            // mode ready: change clears, reach sets
            if (mode_reached)
                flags1_q[rss_pkg::F1_READY_BIT] <= 1'b1;
            else if (mode_chg)
                flags1_q[rss_pkg::F1_READY_BIT] <= 1'b0;
            flags1_q[rss_pkg::F1_RX_BIT] <= in_rx && (rx_settle_done
                || flags1_q[rss_pkg::F1_RX_BIT]);
            flags1_q[rss_pkg::F1_TX_BIT] <= in_tx && (tx_ramp_done
                || flags1_q[rss_pkg::F1_TX_BIT]);
            flags1_q[rss_pkg::F1_LOCK_BIT] <= pll_lock && (mode >= rss_pkg::RSS_FSTX);
            if (in_rx && rssi_above)
                flags1_q[rss_pkg::F1_RSSI_BIT] <= 1'b1;
            else if (!in_rx || w1c_rssi)
                flags1_q[rss_pkg::F1_RSSI_BIT] <= 1'b0;
            if (rx_timeout)
                flags1_q[rss_pkg::F1_TMO_BIT] <= 1'b1;
            else if (!in_rx || fifo_empty)
                flags1_q[rss_pkg::F1_TMO_BIT] <= 1'b0;
            if (preamble_hit)
                flags1_q[rss_pkg::F1_PRE_BIT] <= 1'b1;
            else if (w1c_pre)
                flags1_q[rss_pkg::F1_PRE_BIT] <= 1'b0;
            if (sync_hit)
                flags1_q[rss_pkg::F1_SYNC_BIT] <= 1'b1;
            else if (!in_rx || fifo_empty || w1c_sync)
                flags1_q[rss_pkg::F1_SYNC_BIT] <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // second flag register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            overflow_q <= 1'b0;
            sent_q     <= 1'b0;
            payload_q  <= 1'b0;
            crc_q      <= 1'b0;
            supply_low_flag_q   <= 1'b0;
            fifo_flush <= 1'b0;
        end
        else if (ce)
        begin
            fifo_flush <= w1c_ovr;
            if (fifo_overrun && (mode != rss_pkg::RSS_SLEEP))
                overflow_q <= 1'b1;
            else if (w1c_ovr)
                overflow_q <= 1'b0;
            sent_q    <= in_tx && (packet_done || sent_q);
            if (in_rx && payload_done)
                payload_q <= 1'b1;
            else if (fifo_empty || w1c_ovr)
                payload_q <= 1'b0;
            if (in_rx && crc_good)
                crc_q <= 1'b1;
            else if (fifo_empty || w1c_ovr)
                crc_q <= 1'b0;
            if (supply_detector_enable && supply_below)
                supply_low_flag_q <= 1'b1;
            else if (w1c_bat)
                supply_low_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read data and acknowledge, one wait-free cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end
        else if (ce)
        begin
            wb_ack_o <= req;
            if (req && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    rss_pkg::ADDR_IMAGE_CAL:
                        wb_dat_o <= {auto_rx_calibration_enable, 1'b0,
                                     cal_busy, 1'b0, moved,
                                     temperature_delta_limit_q,
                                     thermal_monitor_disable_q};
                    rss_pkg::ADDR_TEMP:
                        wb_dat_o <= reading;
                    rss_pkg::ADDR_SUPPLY:
                        wb_dat_o <= {4'h0, supply_detector_enable,
                                     supply_threshold_select};
                    rss_pkg::ADDR_FLAGS1:
                        wb_dat_o <= flags1_q;
                    rss_pkg::ADDR_FLAGS2:
                        wb_dat_o <= {(fifo_count == rss_pkg::FIFO_MAX_BYTES),
                                     fifo_empty,
                                     (fifo_count > {1'b0, buffer_level_limit_q}),
                                     overflow_q, sent_q, payload_q, crc_q, supply_low_flag_q};
                    rss_pkg::ADDR_FIFO_LIMIT:
                        wb_dat_o <= {2'h0, buffer_level_limit_q};
                    default:
                        wb_dat_o <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_supply_low_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
        (ce && supply_low_flag_q && !w1c_bat) |=> supply_low_flag_q)
        else $error("low supply flag dropped without write");
    chk_pre_w1c: assert property (@(posedge clk) disable iff (!rstn)
        (ce && w1c_pre && !preamble_hit) |=> !flags1_q[1])
        else $error("preamble flag not cleared");
    chk_rssi_leave: assert property (@(posedge clk) disable iff (!rstn)
        (ce && !in_rx) |=> !flags1_q[3])
        else $error("rssi flag outside receive");
    chk_sent_tx: assert property (@(posedge clk) disable iff (!rstn)
        (ce && !in_tx) |=> !sent_q)
        else $error("sent flag outside transmit");
    chk_cal_run: assert property (@(posedge clk) disable iff (!rstn)
        (ce && cal_start) |=> cal_busy)
        else $error("calibration did not start");
    chk_flush_pulse: assert property (@(posedge clk) disable iff (!rstn)
        (ce && w1c_ovr) |=> fifo_flush)
        else $error("flush missing after overflow clear");
    chk_payload_clr: assert property (@(posedge clk) disable iff (!rstn)
        (ce && fifo_empty && !(in_rx && payload_done)) |=> !payload_q)
        else $error("payload flag held on empty");
    chk_trim_reset: assert property (@(posedge clk)
        $rose(rstn) |-> supply_threshold_select == rss_pkg::RST_SUPPLY_TRIM)
        else $error("trim reset value wrong");

endmodule

// ==== rss_pkg.sv ====
package rss_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte index of each 8-bit register)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_IMAGE_CAL   = 8'h3B;  // image calibration control
    localparam logic [7:0] ADDR_TEMP        = 8'h3C;  // temperature readout
    localparam logic [7:0] ADDR_SUPPLY      = 8'h3D;  // supply detector control
    localparam logic [7:0] ADDR_FLAGS1      = 8'h3E;  // event flags, first
    localparam logic [7:0] ADDR_FLAGS2      = 8'h3F;  // event flags, second
    localparam logic [7:0] ADDR_FIFO_LIMIT  = 8'h35;  // buffer level limit

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CAL_AUTO_BIT    = 7;  // auto_rx_calibration_enable
    localparam int CAL_TRIG_BIT    = 6;  // rx_calibration_trigger
    localparam int CAL_RUN_BIT     = 5;  // rx_calibration_active
    localparam int CAL_MOVED_BIT   = 3;  // temperature_moved_flag
    localparam int CAL_LIMIT_LSB   = 1;  // temperature_delta_limit lsb
    localparam int CAL_MONOFF_BIT  = 0;  // thermal_monitor_disable
    localparam int SUP_EN_BIT      = 3;  // supply_detector_enable
    localparam int F1_READY_BIT    = 7;
    localparam int F1_RX_BIT       = 6;
    localparam int F1_TX_BIT       = 5;
    localparam int F1_LOCK_BIT     = 4;
    localparam int F1_RSSI_BIT     = 3;
    localparam int F1_TMO_BIT      = 2;
    localparam int F1_PRE_BIT      = 1;
    localparam int F1_SYNC_BIT     = 0;
    localparam int F2_FULL_BIT     = 7;
    localparam int F2_EMPTY_BIT    = 6;
    localparam int F2_LEVEL_BIT    = 5;
    localparam int F2_OVR_BIT      = 4;
    localparam int F2_SENT_BIT     = 3;
    localparam int F2_PAYLOAD_BIT  = 2;
    localparam int F2_CRC_BIT      = 1;
    localparam int F2_SUPPLY_LOW_FLAG_BIT   = 0;

    // ------------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [1:0] RST_DELTA_LIMIT  = 2'h1;   // 10 degrees
    localparam logic [2:0] RST_SUPPLY_TRIM  = 3'h2;   // third threshold
    localparam logic [5:0] RST_FIFO_LIMIT   = 6'h0F;
    localparam logic [6:0] FIFO_MAX_BYTES   = 7'h42;  // 66 bytes
    localparam logic [7:0] DELTA_STEP_DEG   = 8'h05;  // degrees per code step
    localparam int         CAL_TIME_US      = 10;     // calibration duration
    localparam int         CLK_MHZ          = 20;
    localparam int         CAL_CYCLES       = CAL_TIME_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        RSS_SLEEP   = 3'b000,
        RSS_STANDBY = 3'b001,
        RSS_FSTX    = 3'b010,
        RSS_TX      = 3'b011,
        RSS_FSRX    = 3'b100,
        RSS_RX      = 3'b101
    } rss_mode_e;

endpackage

// ==== rss_cal_seq.sv ====
// ----------------------------------------------------------------------
// calibration sequencer: runs a fixed-length calibration on a start pulse
// ----------------------------------------------------------------------
module rss_cal_seq
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        start,
    output logic             active,
    output logic             done
);

    typedef enum logic [0:0]
    {
        RSS_CAL_IDLE = 1'b0,
        RSS_CAL_RUN  = 1'b1
    } rss_cal_e;

    rss_cal_e    state_q;  // sequencer state
    logic [15:0] cnt_q;    // cycles remaining

    // state and countdown
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= RSS_CAL_IDLE;
            cnt_q   <= 16'h0000;
            done    <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            unique case (state_q)
                RSS_CAL_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= RSS_CAL_RUN;
                        cnt_q   <= 16'(rss_pkg::CAL_CYCLES - 1);
                    end
                end
                RSS_CAL_RUN:
                begin
                    // a trigger during a run restarts it, so busy never drops under it
                    if (start)
                        cnt_q <= 16'(rss_pkg::CAL_CYCLES - 1);
                    else if (cnt_q == 16'h0000)
                    begin
                        state_q <= RSS_CAL_IDLE;
                        done    <= 1'b1;
                    end
                    else
                        cnt_q <= cnt_q - 16'h0001;
                end
            endcase
        end
    end

    // running indication straight from state
    assign active = (state_q == RSS_CAL_RUN);

endmodule

// ==== rss_temp_mon.sv ====
// ----------------------------------------------------------------------
// temperature monitor: samples sensor, compares to reading at last cal
// ----------------------------------------------------------------------
module rss_temp_mon
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        enable,
    input  wire logic [7:0]  sensor,
    input  wire logic        cal_done,
    input  wire logic [1:0]  delta_limit,
    output logic [7:0]       reading,
    output logic             moved
);

    logic [7:0] ref_q;  // reading captured at last calibration
    logic [7:0] diff;   // magnitude of change
    logic [7:0] lim;    // threshold in degrees

    // sample only while monitoring runs; reference follows calibration
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reading <= 8'h00;
            ref_q   <= 8'h00;
        end
        else if (ce)
        begin
            if (enable)
                reading <= sensor;
            if (cal_done)
                ref_q <= reading;
        end
    end

    // one count per degree, so a plain difference is degrees
    always_comb
    begin
        diff  = (reading > ref_q) ? (reading - ref_q) : (ref_q - reading);
        lim   = 8'((delta_limit + 2'h0) * 1) * rss_pkg::DELTA_STEP_DEG
                + rss_pkg::DELTA_STEP_DEG;
        moved = (diff > lim);
    end

endmodule

// ==== rss_regs_tb_top.sv ====
module rss_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // stimulus, observed outputs, bookkeeping
    // ----------------------------------------------------------------
    logic       clk = 0, rstn = 0, ce = 1, continuous_mode = 0, tx_ramp_done = 0;
    logic       packet_done = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_sel_i = 0;
    logic       mode_reached = 0, rx_settle_done = 0, pll_lock = 0, rssi_above = 0;
    logic       rx_timeout = 0, preamble_hit = 0, sync_hit = 0, fifo_overrun = 0;
    logic       payload_done = 0, crc_good = 0, supply_below = 0;
    logic [2:0] mode = 3'h1;                          // standby
    logic [6:0] fifo_count = 7'h00;
    logic [7:0] wb_adr_i = 8'h00, wb_dat_i = 8'h00, temp_sensor = 8'h00, v, n_flush = 8'h00;
    logic [7:0] wb_dat_o, eq[$];                      // expected read data, oldest first
    logic       wb_ack_o, auto_rx_calibration_enable, rx_calibration_active;
    logic       supply_detector_enable, fifo_flush;
    logic [2:0] supply_threshold_select;
    string      nq[$];                                // name of each pending read
    int         n_errors = 0, num_checks = 0, seed;
    int         cnts[5] = '{1, 15, 16, 65, 66};       // buffer boundaries around 15 and 66
    rss_regs dut (.clk, .rstn, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_dat_o, .wb_ack_o, .mode, .continuous_mode, .mode_reached,
        .rx_settle_done, .tx_ramp_done, .pll_lock, .rssi_above, .rx_timeout, .preamble_hit,
        .sync_hit, .fifo_count, .fifo_overrun, .packet_done, .payload_done, .crc_good,
        .supply_below, .temp_sensor, .auto_rx_calibration_enable, .rx_calibration_active,
        .supply_detector_enable, .supply_threshold_select, .fifo_flush);
    always #25 clk = ~clk;                            // 20 MHz
    // ----------------------------------------------------------------
    // helpers: compare, bus cycle, event pulse, verdict
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one classic cycle; for reads d is the expected data, noted for the monitor
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input string n);
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, w, 1'b1, a, d};
        if (!w)
        begin
            nq.push_back(n);
            eq.push_back(d);
        end
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // one-cycle pulse on the status events, then time for the flags to land
    task automatic pulse(input logic [9:0] p);
        @(posedge clk);
        {mode_reached, rx_settle_done, rssi_above, rx_timeout, preamble_hit, sync_hit,
         payload_done, crc_good, fifo_overrun, supply_below} <= p;
        @(posedge clk);
        {mode_reached, rx_settle_done, rssi_above, rx_timeout, preamble_hit, sync_hit,
         payload_done, crc_good, fifo_overrun, supply_below} <= 10'h000;
        repeat (2) @(posedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // monitor: read data is only valid in the single ack cycle
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (fifo_flush === 1'b1) n_flush <= n_flush + 8'h01;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk(nq.pop_front(), wb_dat_o, eq.pop_front());
    end
    initial
    begin
        repeat (4000) @(posedge clk);                 // far beyond the sequence length
        n_errors++;
        stop_test();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed = 32'h44BB0862;
        temp_sensor <= 8'($random(seed));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        chk("trim_out", {5'h00, supply_threshold_select}, 8'h02);
        bus(1'b0, 8'h3B, 8'h02, "cal_rst");
        bus(1'b0, 8'h3D, 8'h02, "sup_rst");
        bus(1'b0, 8'h00, 8'h00, "unmapped");
        v = 8'h08 | (8'($random(seed)) & 8'h07);
        bus(1'b1, 8'h3D, v | 8'hF0, "");
        bus(1'b0, 8'h3D, v, "sup_rw");
        chk("sup_out", {4'h0, supply_detector_enable, supply_threshold_select}, v);
        bus(1'b1, 8'h3B, 8'hC4, "");
        bus(1'b0, 8'h3B, 8'hA4, "cal_run");
        chk("cal_out", {7'h00, rx_calibration_active}, 8'h01);
        repeat (rss_pkg::CAL_CYCLES) @(posedge clk);
        bus(1'b0, 8'h3B, 8'h84, "cal_done");
        chk("cal_idle", {7'h00, rx_calibration_active}, 8'h00);
        chk("auto_out", {7'h00, auto_rx_calibration_enable}, 8'h01);
        bus(1'b0, 8'h3C, 8'h00, "temp_stby");
        mode <= rss_pkg::RSS_RX;
        pll_lock <= 1'b1;
        fifo_count <= 7'h05;
        pulse(10'h3FC);
        bus(1'b0, 8'h3E, 8'hDF, "flags1_set");
        bus(1'b0, 8'h3F, 8'h06, "flags2_rx");
        bus(1'b0, 8'h3C, temp_sensor, "temp_rx");
        bus(1'b1, 8'h3B, 8'hC4, "");                  // trigger outside standby
        bus(1'b0, 8'h3B, {4'h8, temp_sensor > 8'h0F, 3'h4}, "moved");
        bus(1'b1, 8'h3E, 8'h03, "");
        bus(1'b0, 8'h3E, 8'hDD, "w1c_pre");
        continuous_mode <= 1'b1;
        bus(1'b1, 8'h3E, 8'h09, "");
        bus(1'b0, 8'h3E, 8'hD4, "w1c_rssi");
        fifo_count <= 7'h00;
        bus(1'b0, 8'h3E, 8'hD0, "empty_f1");
        bus(1'b0, 8'h3F, 8'h40, "empty_f2");
        mode <= rss_pkg::RSS_STANDBY;
        bus(1'b0, 8'h3E, 8'h00, "leave_rx");
        pulse(10'h001);
        bus(1'b0, 8'h3F, 8'h41, "supply_low_flag");
        bus(1'b1, 8'h3F, 8'h00, "");
        bus(1'b0, 8'h3F, 8'h41, "w0_keep");
        bus(1'b1, 8'h3F, 8'h01, "");
        bus(1'b0, 8'h3F, 8'h40, "supply_low_flag_clr");
        ce <= 1'b0;                                   // frozen: this low-supply event is lost
        pulse(10'h001);
        ce <= 1'b1;
        foreach (cnts[i])
        begin
            fifo_count <= 7'(cnts[i]);
            bus(1'b0, 8'h3F, {cnts[i] == 66, 1'b0, cnts[i] > 15, 5'h00}, "fifo");
        end
        fifo_count <= 7'h00;
        pulse(10'h002);
        bus(1'b0, 8'h3F, 8'h50, "ovr");
        bus(1'b1, 8'h3F, 8'h10, "");
        bus(1'b0, 8'h3F, 8'h40, "ovr_clr");
        mode <= rss_pkg::RSS_TX;
        {tx_ramp_done, packet_done} <= 2'b11;
        bus(1'b0, 8'h3E, 8'h30, "tx_rdy");
        {tx_ramp_done, packet_done} <= 2'b00;
        bus(1'b0, 8'h3F, 8'h48, "sent");
        mode <= rss_pkg::RSS_STANDBY;
        bus(1'b0, 8'h3F, 8'h40, "tx_left");
        chk("flush", n_flush, 8'h01);
        stop_test();
    end
endmodule
